/* File: verilog/smt_defines.svh */
// Register offsets, reset values and timing constants of the sync timing objects.
`ifndef SMT_DEFINES_SVH
`define SMT_DEFINES_SVH
// ============================================================
// Contract
// - Six output mapping assign entries, count 6, defaults 1600..160D.
// - Four input mapping assign entries, count 4, defaults 1A00..1A05.
// - Output sync parameter count reads 0x20, read-only.
// - Cycle time in ns, default 1 ms, sets the period in free run mode only.
// - DC mode reports shift time SYNC0 to outputs driven, read-only.
// - Read-only capability word 0x4C07.
// - Read-only minimum cycle time 100000 ns.
// - DC mode reports calc-and-copy time needed between SYNC0 and SYNC1.
// - Command write 0 stops, 1 starts cycle time measurement.
// - While measuring, timing entries hold largest values seen.
// - Starting a measurement first clears old maxima.
// - DC mode reports max delay SYNC1 to outputs driven.
// - DC mode, operational: count missed sync manager events, 16 bit.
// - Operational: count cycles overrun or started too early, 16 bit.
// - DC mode: count SYNC0 to SYNC1 spacing too short, 16 bit.
// - DC mode: sync error flag set when outputs were late last cycle.
// - Mode codes 0 free, 1 SM3, 2 SYNC0, 3 SYNC1, 34 SM2.
// ============================================================
// Register byte offsets
`define SMT_RX_COUNT_OFS     8'h00
`define SMT_RX_ENTRY_OFS     8'h04
`define SMT_TX_COUNT_OFS     8'h1C
`define SMT_TX_ENTRY_OFS     8'h20
`define SMT_PARAM_COUNT_OFS  8'h30
`define SMT_MODE_OFS         8'h34
`define SMT_CYCLE_OFS        8'h38
`define SMT_SHIFT_OFS        8'h3C
`define SMT_CAPS_OFS         8'h40
`define SMT_MIN_CYCLE_OFS    8'h44
`define SMT_CALC_OFS         8'h48
`define SMT_MIN_DELAY_OFS    8'h4C
`define SMT_CMD_OFS          8'h50
`define SMT_MAX_DELAY_OFS    8'h54
`define SMT_MISSED_OFS       8'h58
`define SMT_EXCEED_OFS       8'h5C
`define SMT_SHORT_OFS        8'h60
`define SMT_SYNC_ERR_OFS     8'h64
`define SMT_IRQ_STAT_OFS     8'h68
`define SMT_IRQ_MASK_OFS     8'h6C
// ============================================================
// Reset and constant values
`define SMT_RX_COUNT_RST     8'h06
`define SMT_RX_ENTRY_RST     {16'h160D, 16'h160B, 16'h1608, 16'h1605, 16'h1603, 16'h1600}
`define SMT_TX_COUNT_RST     8'h04
`define SMT_TX_ENTRY_RST     {16'h1A05, 16'h1A03, 16'h1A01, 16'h1A00}
`define SMT_PARAM_COUNT      8'h20
`define SMT_MODE_RST         16'h0001
`define SMT_CYCLE_RST        32'h000F4240
`define SMT_CAPS             16'h4C07
`define SMT_MIN_CYCLE_RST    32'h000186A0
`define SMT_MIN_DELAY        32'h00000000
`define SMT_CMD_STOP         16'h0000
`define SMT_CMD_START        16'h0001
// ============================================================
// Timing
`define SMT_CLK_PERIOD_NS    8
`define SMT_MIN_SPACING_NS   10000
`endif

/* File: verilog/smt_pkg.sv */
// Types shared by the sync timing object modules.
package smt_pkg;
    localparam int SMT_EVT_W = 4;
    typedef enum logic [15:0] {
        SMT_MODE_FREE  = 16'h0000,
        SMT_MODE_SM3   = 16'h0001,
        SMT_MODE_SYNC0 = 16'h0002,
        SMT_MODE_SYNC1 = 16'h0003,
        SMT_MODE_SM2   = 16'h0022
    } smt_mode_t;
    typedef struct packed {
        logic [SMT_EVT_W-1:0] s1;
        logic [SMT_EVT_W-1:0] s2;
        logic [SMT_EVT_W-1:0] s3;
        logic [SMT_EVT_W-1:0] level;
        logic [SMT_EVT_W-1:0] pulse;
    } smt_sync_t;
    typedef struct packed {
        logic             awHave;
        logic [7:0]       awAddr;
        logic             wHave;
        logic [31:0]      wData;
        logic [3:0]       wStrb;
        logic             bvalid;
        logic             bErr;
        logic             rvalid;
        logic             rErr;
        logic [31:0]      rdata;
        logic [7:0]       rxCount;
        logic [5:0][15:0] rxEntry;
        logic [7:0]       txCount;
        logic [3:0][15:0] txEntry;
        logic [15:0]      mode;
        logic [31:0]      cycleTime;
        logic [15:0]      cmd;
        logic             measuring;
        logic [31:0]      shiftMax;
        logic [31:0]      minCycle;
        logic [31:0]      calcMax;
        logic [31:0]      delayMax;
        logic [15:0]      missCnt;
        logic [15:0]      exceedCnt;
        logic [15:0]      shortCnt;
        logic             syncErr;
        logic [3:0]       irqStat;
        logic [3:0]       irqMask;
        logic [31:0]      tmrNs;
        logic [31:0]      sinceS0;
        logic [31:0]      sinceS1;
        logic [31:0]      sinceStart;
        logic             pending;
        logic             s1Seen;
        logic             smSeen;
        logic             lateFlag;
        logic             opPrev;
        logic             apply;
    } smt_state_t;
endpackage

/* File: verilog/smt_evt_if.sv */
// Event pulses passed from the pin synchroniser to the timing core.
`timescale 1ns/10ps
interface smt_evt_if;
    logic [smt_pkg::SMT_EVT_W-1:0] pulse;
    modport src (output pulse);
    modport dst (input pulse);
endinterface

/* File: verilog/smt_sync_edge.sv */
// Three-stage pin synchroniser with rising edge pulses.
`timescale 1ns/10ps
module smt_sync_edge (
    input  wire logic                          clk_sys,
    input  wire logic                          rst_n,
    input  wire logic [smt_pkg::SMT_EVT_W-1:0] pinIn,
    smt_evt_if.src                             evt
);
    smt_pkg::smt_sync_t st;
    smt_pkg::smt_sync_t next_st;

    // ============================================================
    // Synchroniser
    // A level change is accepted only once stages two and three agree,
    // which filters single-cycle glitches at the cost of a cycle.
    always_comb
    begin
        next_st       = st;
        next_st.s1    = pinIn;
        next_st.s2    = st.s1;
        next_st.s3    = st.s2;
        for (int i = 0; i < smt_pkg::SMT_EVT_W; i++)
        begin
            if (st.s2[i] == st.s3[i])
            begin
                next_st.level[i] = st.s3[i];
            end
        end
        next_st.pulse = next_st.level & ~st.level;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign evt.pulse = st.pulse;
endmodule

/* File: verilog/smt_timing_objects.sv */
// Sync manager assign lists, output sync parameters and timing monitor.
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "smt_defines.svh"
module smt_timing_objects #(
    parameter logic [31:0] MIN_SPACING_NS = `SMT_MIN_SPACING_NS
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        sync0Pin,
    input  wire logic        sync1Pin,
    input  wire logic        smOutEvtPin,
    input  wire logic        smInEvtPin,
    input  wire logic        opState,
    input  wire logic        outputsDone,
    output logic             applyOutputs,
    output logic             irq
);
    localparam logic [31:0] STEP_NS = 32'(`SMT_CLK_PERIOD_NS);
    localparam smt_pkg::smt_state_t RESET_ST = '{
        rxCount:   `SMT_RX_COUNT_RST,
        rxEntry:   `SMT_RX_ENTRY_RST,
        txCount:   `SMT_TX_COUNT_RST,
        txEntry:   `SMT_TX_ENTRY_RST,
        mode:      `SMT_MODE_RST,
        cycleTime: `SMT_CYCLE_RST,
        minCycle:  `SMT_MIN_CYCLE_RST,
        default:   '0
    };

    smt_pkg::smt_state_t st;
    smt_pkg::smt_state_t next_st;
    smt_evt_if           evt ();

    logic p0;
    logic p1;
    logic pSm2;
    logic pSm3;

    // ============================================================
    // Helpers
    function automatic logic [31:0] merge32(
        input logic [31:0] old,
        input logic [31:0] val,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[b*8 +: 8] = val[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Elapsed time saturates so a stopped sync source never wraps to small.
    function automatic logic [31:0] addNs(input logic [31:0] v);
        return (v > (32'hFFFFFFFF - STEP_NS)) ? 32'hFFFFFFFF : v + STEP_NS;
    endfunction

    function automatic logic [15:0] inc16(input logic [15:0] v);
        return (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    function automatic logic [31:0] max32(input logic [31:0] a, input logic [31:0] b);
        return (a > b) ? a : b;
    endfunction

    function automatic logic [32:0] readReg(
        input smt_pkg::smt_state_t s,
        input logic [7:0]          a
    );
        logic [32:0] r;
        r = {1'b0, 32'h00000000};
        unique case (a)
            `SMT_RX_COUNT_OFS:    r[7:0]  = s.rxCount;
            `SMT_TX_COUNT_OFS:    r[7:0]  = s.txCount;
            `SMT_PARAM_COUNT_OFS: r[7:0]  = `SMT_PARAM_COUNT;
            `SMT_MODE_OFS:        r[15:0] = s.mode;
            `SMT_CYCLE_OFS:       r[31:0] = s.cycleTime;
            `SMT_SHIFT_OFS:       r[31:0] = s.shiftMax;
            `SMT_CAPS_OFS:        r[15:0] = `SMT_CAPS;
            `SMT_MIN_CYCLE_OFS:   r[31:0] = s.minCycle;
            `SMT_CALC_OFS:        r[31:0] = s.calcMax;
            `SMT_MIN_DELAY_OFS:   r[31:0] = `SMT_MIN_DELAY;
            `SMT_CMD_OFS:         r[15:0] = s.cmd;
            `SMT_MAX_DELAY_OFS:   r[31:0] = s.delayMax;
            `SMT_MISSED_OFS:      r[15:0] = s.missCnt;
            `SMT_EXCEED_OFS:      r[15:0] = s.exceedCnt;
            `SMT_SHORT_OFS:       r[15:0] = s.shortCnt;
            `SMT_SYNC_ERR_OFS:    r[0]    = s.syncErr;
            `SMT_IRQ_STAT_OFS:    r[3:0]  = s.irqStat;
            `SMT_IRQ_MASK_OFS:    r[3:0]  = s.irqMask;
            default:
            begin
                r[32] = 1'b1;
                for (int i = 0; i < 6; i++)
                    if (a == 8'(`SMT_RX_ENTRY_OFS + 4 * i))
                        r = {1'b0, 16'h0000, s.rxEntry[i]};
                for (int i = 0; i < 4; i++)
                    if (a == 8'(`SMT_TX_ENTRY_OFS + 4 * i))
                        r = {1'b0, 16'h0000, s.txEntry[i]};
            end
        endcase
        return r;
    endfunction

    // ============================================================
    // Pin events
    smt_sync_edge u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pinIn   ({smInEvtPin, smOutEvtPin, sync1Pin, sync0Pin}),
        .evt     (evt.src)
    );

    assign p0   = evt.pulse[0];
    assign p1   = evt.pulse[1];
    assign pSm2 = evt.pulse[2];
    assign pSm3 = evt.pulse[3];

    // ============================================================
    // Next state
    always_comb
    begin
        logic        isDc;
        logic        tick;
        logic        start;
        logic        pendNow;
        logic        doWrite;
        logic [31:0] wv;
        logic [3:0]  clr;
        logic [3:0]  set;
        logic [32:0] rd;
        logic [31:0] need;
        isDc    = 1'b0;
        tick    = 1'b0;
        start   = 1'b0;
        pendNow = 1'b0;
        doWrite = 1'b0;
        wv      = 32'h00000000;
        clr     = 4'h0;
        set     = 4'h0;
        rd      = 33'h000000000;
        need    = 32'h00000000;
        next_st = st;

        isDc = (st.mode == smt_pkg::SMT_MODE_SYNC0) || (st.mode == smt_pkg::SMT_MODE_SYNC1);

        // Free run local timer with the programmed period.
        tick          = addNs(st.tmrNs) >= st.cycleTime;
        next_st.tmrNs = tick ? 32'h00000000 : addNs(st.tmrNs);

        // Cycle trigger follows the selected mode; unknown codes never start.
        case (st.mode)
            smt_pkg::SMT_MODE_FREE:  start = tick;
            smt_pkg::SMT_MODE_SM3:   start = pSm3;
            smt_pkg::SMT_MODE_SYNC0: start = p0;
            smt_pkg::SMT_MODE_SYNC1: start = p1;
            smt_pkg::SMT_MODE_SM2:   start = pSm2;
            default:                 start = 1'b0;
        endcase
        next_st.apply = start;

        next_st.sinceS0    = p0 ? 32'h00000000 : addNs(st.sinceS0);
        next_st.sinceS1    = p1 ? 32'h00000000 : addNs(st.sinceS1);
        next_st.sinceStart = start ? 32'h00000000 : addNs(st.sinceStart);

        // Outputs applied: collect maxima while a measurement runs.
        pendNow = st.pending && !outputsDone;
        if (outputsDone && st.pending)
        begin
            next_st.pending = 1'b0;
            if (isDc && st.s1Seen)
                next_st.lateFlag = 1'b1;
            if (st.measuring)
            begin
                next_st.calcMax = max32(st.calcMax, st.sinceStart);
                if (isDc)
                    next_st.shiftMax = max32(st.shiftMax, st.sinceS0);
                if (isDc && st.s1Seen)
                    next_st.delayMax = max32(st.delayMax, st.sinceS1);
            end
        end

        if (start)
        begin
            if (opState && pendNow)
            begin
                next_st.exceedCnt = inc16(st.exceedCnt);
                set[1]            = 1'b1;
            end
            if (st.measuring)
                next_st.minCycle = max32(st.minCycle, st.sinceStart);
            next_st.pending = 1'b1;
        end

        // SYNC0 closes a distributed clock cycle.
        if (p0)
        begin
            if (isDc)
            begin
                next_st.syncErr = st.lateFlag || next_st.lateFlag || pendNow;
                if (opState && !st.smSeen && !pSm2)
                begin
                    next_st.missCnt = inc16(st.missCnt);
                    set[0]          = 1'b1;
                end
            end
            next_st.lateFlag = 1'b0;
            next_st.s1Seen   = 1'b0;
            next_st.smSeen   = pSm2;
        end
        else if (pSm2)
        begin
            next_st.smSeen = 1'b1;
        end
        if (!isDc)
        begin
            next_st.syncErr = 1'b0;
        end
        set[3] = next_st.syncErr && !st.syncErr;

        // Required spacing grows with the measured processing time.
        need = max32(MIN_SPACING_NS, st.calcMax);
        if (p1)
        begin
            next_st.s1Seen = 1'b1;
            if (isDc && !p0 && st.sinceS0 < need)
            begin
                next_st.shortCnt = inc16(st.shortCnt);
                set[2]           = 1'b1;
            end
        end

        if (opState && !st.opPrev)
        begin
            next_st.missCnt   = 16'h0000;
            next_st.exceedCnt = 16'h0000;
            next_st.shortCnt  = 16'h0000;
        end
        next_st.opPrev = opState;

        // Write address and data are captured independently.
        if (s_axi_awvalid && !st.awHave)
        begin
            next_st.awHave = 1'b1;
            next_st.awAddr = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && !st.wHave)
        begin
            next_st.wHave = 1'b1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready)
            next_st.bvalid = 1'b0;

        doWrite = st.awHave && st.wHave && !st.bvalid;
        if (doWrite)
        begin
            next_st.awHave = 1'b0;
            next_st.wHave  = 1'b0;
            next_st.bvalid = 1'b1;
            rd             = readReg(st, st.awAddr);
            wv             = merge32(rd[31:0], st.wData, st.wStrb);
            next_st.bErr   = rd[32];
            unique case (st.awAddr)
                `SMT_RX_COUNT_OFS:  next_st.rxCount   = wv[7:0];
                `SMT_TX_COUNT_OFS:  next_st.txCount   = wv[7:0];
                `SMT_MODE_OFS:      next_st.mode      = wv[15:0];
                `SMT_CYCLE_OFS:     next_st.cycleTime = wv;
                `SMT_CMD_OFS:
                begin
                    next_st.cmd = wv[15:0];
                    if (wv[15:0] == `SMT_CMD_START)
                    begin
                        next_st.measuring = 1'b1;
                        next_st.shiftMax  = 32'h00000000;
                        next_st.minCycle  = 32'h00000000;
                        next_st.calcMax   = 32'h00000000;
                        next_st.delayMax  = 32'h00000000;
                    end
                    else if (wv[15:0] == `SMT_CMD_STOP)
                        next_st.measuring = 1'b0;
                end
                `SMT_IRQ_STAT_OFS:  clr = st.wStrb[0] ? st.wData[3:0] : 4'h0;
                `SMT_IRQ_MASK_OFS:  next_st.irqMask = wv[3:0];
                default:
                begin
                    for (int i = 0; i < 6; i++)
                        if (st.awAddr == 8'(`SMT_RX_ENTRY_OFS + 4 * i))
                            next_st.rxEntry[i] = wv[15:0];
                    for (int i = 0; i < 4; i++)
                        if (st.awAddr == 8'(`SMT_TX_ENTRY_OFS + 4 * i))
                            next_st.txEntry[i] = wv[15:0];
                end
            endcase
        end

        // A new event wins over a clear written in the same cycle.
        next_st.irqStat = (st.irqStat & ~clr) | set;

        // Read answers one cycle after the address is taken.
        if (st.rvalid && s_axi_rready)
            next_st.rvalid = 1'b0;
        if (s_axi_arvalid && !st.rvalid)
        begin
            rd             = readReg(st, {s_axi_araddr[7:2], 2'b00});
            next_st.rvalid = 1'b1;
            next_st.rErr   = rd[32];
            next_st.rdata  = rd[31:0];
        end
    end

    // ============================================================
    // State register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= RESET_ST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ============================================================
    // Outputs
    assign s_axi_awready = !st.awHave;
    assign s_axi_wready  = !st.wHave;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = {st.bErr, 1'b0};
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rresp   = {st.rErr, 1'b0};
    assign s_axi_rdata   = st.rdata;
    assign applyOutputs  = st.apply;
    assign irq           = |(st.irqStat & st.irqMask);
endmodule

/* File: verif/smt_props.sv */
// Port-level assertions for the sync timing objects.
`timescale 1ns/10ps
// ============================================================
// Checker
module smt_props #(
    parameter logic [31:0] MIN_SPACING_NS = 32'h00002710
) (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        applyOutputs
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("Write response dropped early.");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("Read data changed while held.");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read address accepted while data held.");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read answer late.");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("Write answer late.");
    apply_pulse_a: assert property (applyOutputs |=> !applyOutputs)
        else $error("Apply pulse longer than one cycle.");
    param_count_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 8'h30 |=> s_axi_rdata == 32'h00000020)
        else $error("Parameter count wrong.");
    caps_word_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 8'h40 |=> s_axi_rdata == 32'h00004C07)
        else $error("Capability word wrong.");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[7:2] > 6'h1B |=> s_axi_rresp == 2'b10)
        else $error("Unmapped read not refused.");
endmodule
bind smt_timing_objects smt_props #(.MIN_SPACING_NS(MIN_SPACING_NS)) smt_props_i (
    .clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .applyOutputs
);

/* File: verif/smt_evt_master.sv */
// Event pin source standing in for the master's timing side.
`timescale 1ns/10ps
// ============================================================
// Pins idle low; each event holds three clocks, above the two the synchroniser needs.
module smt_evt_master (
    input  wire logic       clk_sys,
    output logic      [3:0] pins
);
    initial pins = 4'h0;
    task automatic fire(input int b);
        @(posedge clk_sys);
        pins[b] <= 1'b1;
        repeat (3) @(posedge clk_sys);
        pins[b] <= 1'b0;
    endtask
endmodule

/* File: verif/smt_testbench.sv */
// Self-checking bench for the sync timing objects.
`timescale 1ns/10ps
module testbench;
    logic clk_sys = 1'b0, rst_n = 1'b0, opState = 1'b0, outputsDone = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb = 4'hF, pins;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic applyOutputs, irq;
    int errors = 0, checks_done = 0, seed = 12, cyc = 0, applies = 0;
    logic [15:0] modes[5] = '{16'h0000, 16'h0001, 16'h0003, 16'h0022, 16'h0002};
    logic [31:0] mdl[logic [7:0]] = '{8'h00: 6, 8'h04: 16'h1600, 8'h08: 16'h1603,
        8'h0C: 16'h1605, 8'h10: 16'h1608, 8'h14: 16'h160B, 8'h18: 16'h160D, 8'h1C: 4,
        8'h20: 16'h1A00, 8'h24: 16'h1A01, 8'h28: 16'h1A03, 8'h2C: 16'h1A05, 8'h30: 32,
        8'h34: 1, 8'h38: 32'h000F4240, 8'h40: 16'h4C07, 8'h44: 32'h000186A0,
        8'h4C: 0, 8'h50: 0, 8'h58: 0, 8'h5C: 0, 8'h60: 0, 8'h64: 0};
    // A short spacing limit keeps the too-close test within a few dozen clocks.
    smt_timing_objects #(.MIN_SPACING_NS(32'h000000C8)) smt_timing_objects_i (
        .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sync0Pin(pins[0]), .sync1Pin(pins[1]),
        .smOutEvtPin(pins[2]), .smInEvtPin(pins[3]), .opState, .outputsDone,
        .applyOutputs, .irq
    );
    smt_evt_master smt_evt_master_i (.clk_sys, .pins);
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc++;
        if (applyOutputs)
            applies++;
        if (cyc == 20000)
        begin
            errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rp);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        rp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rp);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        rp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic sweep();
        foreach (mdl[k])
        begin
            rd(k, v, r);
            chk(v, mdl[k]);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        sweep();
        $display("reset values done");
        for (int a = 0; a < 48; a += 4)
        begin
            v = $random(seed);
            s_axi_wstrb <= 4'($random(seed));
            wr(a[7:0], v, r);
            for (int b = 0; b < 4; b++)
                if (s_axi_wstrb[b])
                    mdl[a[7:0]][b*8 +: 8] = v[b*8 +: 8];
            mdl[a[7:0]] &= (a == 0 || a == 28) ? 32'hFF : 32'hFFFF;
        end
        s_axi_wstrb <= 4'hF;
        wr(8'h30, $random(seed), r);
        chk(r, 2'b00);
        wr(8'h70, $random(seed), r);
        chk(r, 2'b10);
        rd(8'h70, v, r);
        chk(r, 2'b10);
        foreach (modes[i])
        begin
            wr(8'h34, modes[i], r);
            rd(8'h34, v, r);
            chk(v, modes[i]);
        end
        mdl[8'h34] = 2;
        wr(8'h38, 32'h00000320, r);
        mdl[8'h38] = 32'h00000320;
        $display("register writes done");
        // Retire any free-run cycle so the first synchronised cycle is not an overrun.
        @(posedge clk_sys) outputsDone <= 1'b1;
        @(posedge clk_sys) outputsDone <= 1'b0;
        wr(8'h50, 1, r);
        rd(8'h44, v, r);
        chk(v, 32'h0);
        @(posedge clk_sys) opState <= 1'b1;
        smt_evt_master_i.fire(2);
        repeat (2)
        begin
            smt_evt_master_i.fire(0);
            repeat (40) @(posedge clk_sys);
        end
        smt_evt_master_i.fire(0);
        repeat (6) @(posedge clk_sys);
        smt_evt_master_i.fire(1);
        repeat (20) @(posedge clk_sys);
        mdl[8'h58] = 2;
        mdl[8'h5C] = 2;
        mdl[8'h60] = 1;
        mdl[8'h64] = 1;
        mdl.delete(8'h44);
        wr(8'h50, 0, r);
        sweep();
        $display("event counters done");
        wr(8'h6C, 1, r);
        @(posedge clk_sys);
        chk({31'h0, irq}, 1);
        wr(8'h68, 1, r);
        @(posedge clk_sys);
        chk({31'h0, irq}, 0);
        $display("interrupt done");
        wr(8'h34, 1, r);
        smt_evt_master_i.fire(3);
        repeat (8) @(posedge clk_sys);
        chk(applies, 4);
        $display("sync mode done");
        end_of_test();
    end
endmodule
